// file: verilog/dpm_core.v
/*
  Protocol side of a fieldbus option card: profile/bypass mode choice,
  SDO server (expedited, normal, segmented, abort), emergency reports,
  network state and node address alarm.
  Assumes a bus stack that delivers decoded SDO requests one at a time
  and a drive that exchanges native 16-bit command and status words.
*/
`timescale 1ns/1ps
`include "dpm_regs.vh"

module dpm_core (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Network state requests
  input  wire        al_req_valid,
  input  wire [3:0]  al_req_state,
  output reg  [3:0]  net_state_q,
  // Process data
  input  wire        rxpdo_has_ctrl,
  input  wire        pdo_valid,
  input  wire [15:0] pdo_word,
  // SDO requests
  input  wire        sdo_req_valid,
  output wire        sdo_req_ready,
  input  wire [2:0]  sdo_req_cmd,
  input  wire [15:0] sdo_req_index,
  input  wire [7:0]  sdo_req_sub,
  input  wire [31:0] sdo_req_data,
  input  wire [3:0]  sdo_req_size,
  // SDO responses
  output wire        sdo_rsp_valid,
  input  wire        sdo_rsp_ready,
  output reg  [2:0]  sdo_rsp_cmd_q,
  output reg  [31:0] sdo_rsp_data_q,
  output reg  [3:0]  sdo_rsp_size_q,
  output reg         sdo_rsp_normal_q,
  output reg         sdo_rsp_last_q,
  output reg         sdo_rsp_abort_q,
  output reg  [31:0] sdo_rsp_code_q,
  // Drive side
  output reg  [15:0] drv_cmd_q,
  input  wire [15:0] drv_sts,
  input  wire        drive_fault,
  input  wire        adapter_fault,
  // Emergency
  output reg         emcy_valid_q,
  output reg  [15:0] emcy_code_q,
  input  wire        emcy_rx_valid,
  output reg         emcy_rx_refused_q,
  // Mode and settings
  output reg         profile_active_q,
  output reg  [7:0]  mode_display_q,
  input  wire [7:0]  node_addr_in,
  input  wire [1:0]  comm_speed_in,
  output reg  [7:0]  node_addr_q,
  output reg  [1:0]  comm_speed_q,
  output reg         node_address_alarm_q
);

  localparam S_IDLE = 1'b0;
  localparam S_RSP  = 1'b1;

  function [3:0] obj_size;
    input [15:0] idx;
    begin
      case (idx)
        `DPM_OBJ_CTRL, `DPM_OBJ_STAT,
        `DPM_OBJ_VCMD, `DPM_OBJ_VSTS: obj_size = `DPM_SIZE_WORD;
        `DPM_OBJ_MODE:                obj_size = `DPM_SIZE_BYTE;
        `DPM_OBJ_VBUF:                obj_size = `DPM_SIZE_VBUF;
        default:                      obj_size = 4'h0;
      endcase
    end
  endfunction

  function obj_ro;
    input [15:0] idx;
    begin
      obj_ro = idx == `DPM_OBJ_STAT || idx == `DPM_OBJ_MODE || idx == `DPM_OBJ_VSTS;
    end
  endfunction

  reg        rs1_q;
  reg        rs2_q;
  wire       rst_sync_n = rs2_q;
  reg        st_q;
  reg        sdo_sel_q;
  reg        seg_act_q;
  reg        seg_up_q;
  reg        seg_ptr_q;
  reg [15:0] sdo_cw_q;
  reg [15:0] vcmd_q;
  reg [15:0] pdo_word_q;
  reg        pdo_seen_q;
  reg        cap_done_q;
  reg        dflt_q;
  reg        aflt_q;
  reg [1:0]  emcy_pend_q;
  reg [31:0] vbuf_mem [0:1];

  wire [3:0]  osz      = obj_size(sdo_req_index);
  wire        known    = osz != 4'h0;
  wire        in_sop   = net_state_q == `DPM_NS_SAFEOP || net_state_q == `DPM_NS_OP;
  wire        is_op    = net_state_q == `DPM_NS_OP;
  wire        pdo_prof = rxpdo_has_ctrl && in_sop;
  wire        profile  = pdo_prof || sdo_sel_q;
  wire        req_take = sdo_req_valid && sdo_req_ready;
  wire        is_ctrl  = sdo_req_index == `DPM_OBJ_CTRL;
  // Profile objects locked only once the state can no longer switch the mode
  wire        ctl_lock = (is_ctrl || sdo_req_index == `DPM_OBJ_STAT) && !profile && in_sop;
  wire        seg_dn   = seg_act_q && !seg_up_q;
  wire        mem_we   = req_take && sdo_req_cmd == `DPM_CMD_DL_SEG && seg_dn;
  wire [15:0] eff_cw   = pdo_seen_q ? pdo_word_q : sdo_cw_q;
  wire [15:0] eff_vcmd = pdo_seen_q ? pdo_word_q : vcmd_q;
  wire [15:0] prof_cmd;
  wire [15:0] prof_sw;
  wire        ns_ok    = al_req_state == `DPM_NS_INIT || al_req_state == `DPM_NS_PREOP ||
                         al_req_state == `DPM_NS_SAFEOP || al_req_state == `DPM_NS_OP;
  wire        to_safe  = al_req_valid && ns_ok && al_req_state == `DPM_NS_SAFEOP &&
                         net_state_q == `DPM_NS_PREOP;

  assign sdo_req_ready = st_q == S_IDLE;
  assign sdo_rsp_valid = st_q == S_RSP;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  dpm_profile u_profile (
    .clock       (clock),
    .rst_n       (rst_sync_n),
    .enable      (profile),
    .ctrl_word   (eff_cw),
    .drv_sts     (drv_sts),
    .drv_cmd_q   (prof_cmd),
    .stat_word_q (prof_sw)
  );

  // Segment buffer holds no control state, so it needs no reset
  always @(posedge clock) begin
    if (mem_we)
      vbuf_mem[seg_ptr_q] <= sdo_req_data;
  end

  // Network state, process data and drive command
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      net_state_q      <= `DPM_NS_INIT;
      pdo_word_q       <= `DPM_WORD_RST;
      pdo_seen_q       <= 1'b0;
      drv_cmd_q        <= `DPM_WORD_RST;
      profile_active_q <= 1'b0;
      mode_display_q   <= `DPM_MODE_BYPASS;
    end else begin
      if (al_req_valid && ns_ok)
        net_state_q <= al_req_state;
      if (!is_op) begin
        pdo_word_q <= `DPM_WORD_RST;
        pdo_seen_q <= 1'b0;
      end else if (pdo_valid) begin
        pdo_word_q <= pdo_word;
        pdo_seen_q <= 1'b1;
      end
      drv_cmd_q        <= profile ? prof_cmd : eff_vcmd;
      profile_active_q <= profile;
      mode_display_q   <= profile ? `DPM_MODE_PROFILE : `DPM_MODE_BYPASS;
    end
  end

  // Settings are latched once after reset release and then frozen
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cap_done_q           <= 1'b0;
      node_addr_q          <= 8'h00;
      comm_speed_q         <= 2'h0;
      node_address_alarm_q <= 1'b0;
    end else if (!cap_done_q) begin
      cap_done_q           <= 1'b1;
      node_addr_q          <= node_addr_in;
      comm_speed_q         <= comm_speed_in;
      node_address_alarm_q <= node_addr_in == 8'h00;
    end
  end

  // Emergency reports on fault onset; one pending flag per source
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dflt_q            <= 1'b0;
      aflt_q            <= 1'b0;
      emcy_pend_q       <= 2'h0;
      emcy_valid_q      <= 1'b0;
      emcy_code_q       <= `DPM_WORD_RST;
      emcy_rx_refused_q <= 1'b0;
    end else begin
      dflt_q            <= drive_fault;
      aflt_q            <= adapter_fault;
      emcy_rx_refused_q <= emcy_rx_valid;
      emcy_valid_q      <= 1'b0;
      if (emcy_pend_q[0]) begin
        emcy_valid_q <= 1'b1;
        emcy_code_q  <= `DPM_EMCY_DRIVE;
      end else if (emcy_pend_q[1]) begin
        emcy_valid_q <= 1'b1;
        emcy_code_q  <= `DPM_EMCY_ADAPT;
      end
      // New onset wins over the clear of the flag being served
      emcy_pend_q[0] <= drive_fault && !dflt_q;
      emcy_pend_q[1] <= (adapter_fault && !aflt_q) ||
                        (emcy_pend_q[1] && emcy_pend_q[0]);
    end
  end

  // SDO server
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q             <= S_IDLE;
      sdo_sel_q        <= 1'b0;
      seg_act_q        <= 1'b0;
      seg_up_q         <= 1'b0;
      seg_ptr_q        <= 1'b0;
      sdo_cw_q         <= `DPM_WORD_RST;
      vcmd_q           <= `DPM_WORD_RST;
      sdo_rsp_cmd_q    <= 3'h0;
      sdo_rsp_data_q   <= 32'h00000000;
      sdo_rsp_size_q   <= 4'h0;
      sdo_rsp_normal_q <= 1'b0;
      sdo_rsp_last_q   <= 1'b0;
      sdo_rsp_abort_q  <= 1'b0;
      sdo_rsp_code_q   <= 32'h00000000;
    end else begin
      if (to_safe)
        sdo_sel_q <= 1'b0;
      if (st_q == S_RSP && sdo_rsp_ready)
        st_q <= S_IDLE;
      if (req_take) begin
        st_q             <= S_RSP;
        sdo_rsp_cmd_q    <= sdo_req_cmd;
        sdo_rsp_data_q   <= 32'h00000000;
        sdo_rsp_size_q   <= 4'h0;
        sdo_rsp_normal_q <= 1'b0;
        sdo_rsp_last_q   <= 1'b0;
        sdo_rsp_abort_q  <= 1'b1;
        sdo_rsp_code_q   <= `DPM_AB_CMD;
        case (sdo_req_cmd)
          `DPM_CMD_DL_EXP, `DPM_CMD_DL_INIT: begin
            seg_act_q <= 1'b0;
            if (!known)
              sdo_rsp_code_q <= `DPM_AB_NOOBJ;
            else if (sdo_req_sub != 8'h00)
              sdo_rsp_code_q <= `DPM_AB_SUB;
            else if (obj_ro(sdo_req_index))
              sdo_rsp_code_q <= `DPM_AB_RO;
            else if (ctl_lock)
              sdo_rsp_code_q <= `DPM_AB_STATE;
            else if (sdo_req_cmd == `DPM_CMD_DL_INIT) begin
              if (osz <= `DPM_EXP_MAX)
                sdo_rsp_code_q <= `DPM_AB_CMD;
              else if (sdo_req_data != {28'h0000000, osz})
                sdo_rsp_code_q <= `DPM_AB_LEN;
              else begin
                sdo_rsp_abort_q <= 1'b0;
                sdo_rsp_code_q  <= 32'h00000000;
                seg_act_q       <= 1'b1;
                seg_up_q        <= 1'b0;
                seg_ptr_q       <= 1'b0;
              end
            end else if (sdo_req_size > `DPM_EXP_MAX || osz > `DPM_EXP_MAX)
              sdo_rsp_code_q <= `DPM_AB_LEN;
            else begin
              sdo_rsp_abort_q <= 1'b0;
              sdo_rsp_code_q  <= 32'h00000000;
              if (is_ctrl) begin
                sdo_cw_q <= sdo_req_data[15:0];
                if (!in_sop)
                  sdo_sel_q <= 1'b1;
              end else
                vcmd_q <= sdo_req_data[15:0];
            end
          end
          `DPM_CMD_DL_SEG: begin
            if (seg_dn) begin
              sdo_rsp_abort_q <= 1'b0;
              sdo_rsp_code_q  <= 32'h00000000;
              sdo_rsp_last_q  <= seg_ptr_q;
              seg_ptr_q       <= !seg_ptr_q;
              seg_act_q       <= !seg_ptr_q;
            end else
              seg_act_q <= 1'b0;
          end
          `DPM_CMD_UL_REQ: begin
            seg_act_q <= 1'b0;
            if (!known)
              sdo_rsp_code_q <= `DPM_AB_NOOBJ;
            else if (sdo_req_sub != 8'h00)
              sdo_rsp_code_q <= `DPM_AB_SUB;
            else if (ctl_lock)
              sdo_rsp_code_q <= `DPM_AB_STATE;
            else begin
              sdo_rsp_abort_q <= 1'b0;
              sdo_rsp_code_q  <= 32'h00000000;
              sdo_rsp_size_q  <= osz;
              case (sdo_req_index)
                `DPM_OBJ_CTRL: sdo_rsp_data_q <= {16'h0000, sdo_cw_q};
                `DPM_OBJ_STAT: begin
                  sdo_rsp_data_q <= {16'h0000, prof_sw};
                  if (!in_sop)
                    sdo_sel_q <= 1'b1;
                end
                `DPM_OBJ_MODE: sdo_rsp_data_q <= {24'h000000, mode_display_q};
                `DPM_OBJ_VCMD: sdo_rsp_data_q <= {16'h0000, vcmd_q};
                `DPM_OBJ_VSTS: sdo_rsp_data_q <= {16'h0000, drv_sts};
                default: begin
                  sdo_rsp_data_q   <= {28'h0000000, osz};
                  sdo_rsp_size_q   <= `DPM_EXP_MAX;
                  sdo_rsp_normal_q <= 1'b1;
                  seg_act_q        <= 1'b1;
                  seg_up_q         <= 1'b1;
                  seg_ptr_q        <= 1'b0;
                end
              endcase
            end
          end
          `DPM_CMD_UL_SEG: begin
            if (seg_act_q && seg_up_q) begin
              sdo_rsp_abort_q <= 1'b0;
              sdo_rsp_code_q  <= 32'h00000000;
              sdo_rsp_data_q  <= vbuf_mem[seg_ptr_q];
              sdo_rsp_size_q  <= `DPM_EXP_MAX;
              sdo_rsp_last_q  <= seg_ptr_q;
              seg_ptr_q       <= !seg_ptr_q;
              seg_act_q       <= !seg_ptr_q;
            end else
              seg_act_q <= 1'b0;
          end
          `DPM_CMD_ABORT: begin
            st_q      <= S_IDLE;
            seg_act_q <= 1'b0;
          end
          default: seg_act_q <= 1'b0;
        endcase
      end
    end
  end

endmodule

// file: pkg/dpm_regs.vh
/*
  Constants for the drive profile / SDO service block: object indices,
  command and abort codes, mode display values and word bit positions.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DPM_REGS_VH
`define DPM_REGS_VH

// Object indices and sizes
`define DPM_OBJ_CTRL     16'h6040
`define DPM_OBJ_STAT     16'h6041
`define DPM_OBJ_MODE     16'h6061
`define DPM_OBJ_VCMD     16'h2001
`define DPM_OBJ_VSTS     16'h2002
`define DPM_OBJ_VBUF     16'h2100
`define DPM_SIZE_WORD    4'h2
`define DPM_SIZE_BYTE    4'h1
`define DPM_SIZE_VBUF    4'h8
`define DPM_EXP_MAX      4'h4

// Mode display values
`define DPM_MODE_PROFILE 8'h02
`define DPM_MODE_BYPASS  8'hFE

// Network states
`define DPM_NS_INIT      4'h1
`define DPM_NS_PREOP     4'h2
`define DPM_NS_SAFEOP    4'h4
`define DPM_NS_OP        4'h8

// SDO request codes
`define DPM_CMD_DL_EXP   3'h0
`define DPM_CMD_DL_INIT  3'h1
`define DPM_CMD_DL_SEG   3'h2
`define DPM_CMD_UL_REQ   3'h3
`define DPM_CMD_UL_SEG   3'h4
`define DPM_CMD_ABORT    3'h5

// Abort codes
`define DPM_AB_CMD       32'h05040001
`define DPM_AB_RO        32'h06010002
`define DPM_AB_NOOBJ     32'h06020000
`define DPM_AB_LEN       32'h06070010
`define DPM_AB_SUB       32'h06090011
`define DPM_AB_STATE     32'h08000022

// Emergency codes
`define DPM_EMCY_DRIVE   16'hFF00
`define DPM_EMCY_ADAPT   16'h5000

// Reset values
`define DPM_WORD_RST     16'h0000

// Profile control word bits
`define DPM_CW_SWON      0
`define DPM_CW_ENV       1
`define DPM_CW_QSTOP     2
`define DPM_CW_ENOP      3
`define DPM_CW_FRST      6
`define DPM_CW_HALT      7

// Profile status word bits
`define DPM_SW_RDY       0
`define DPM_SW_SWON      1
`define DPM_SW_OPEN      2
`define DPM_SW_FLT       3
`define DPM_SW_VEN       4
`define DPM_SW_QS        5
`define DPM_SW_SOD       6

// Native drive command / status bits
`define DPM_DC_RUN       0
`define DPM_DC_FRST      1
`define DPM_DS_FLT       1
`define DPM_DS_RDY       2

`endif

// file: verilog/dpm_profile.v
/*
  Reduced drive profile state machine: turns a profile control word into
  a native drive command and builds the profile status word.
  Assumes a synchronous, already released reset and a single clock.
*/
`timescale 1ns/1ps
`include "dpm_regs.vh"

module dpm_profile (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Control
  input  wire        enable,
  input  wire [15:0] ctrl_word,
  input  wire [15:0] drv_sts,
  // Results
  output reg  [15:0] drv_cmd_q,
  output reg  [15:0] stat_word_q
);

  localparam [2:0] P_SOD  = 3'h0;
  localparam [2:0] P_RTSO = 3'h1;
  localparam [2:0] P_SWON = 3'h2;
  localparam [2:0] P_OPEN = 3'h3;
  localparam [2:0] P_FLT  = 3'h4;

  reg  [2:0] st_q;
  reg  [2:0] st_d;
  wire       shut = ctrl_word[`DPM_CW_ENV] & ctrl_word[`DPM_CW_QSTOP];
  wire       flt  = drv_sts[`DPM_DS_FLT];

  always @* begin
    st_d = st_q;
    case (st_q)
      P_SOD:  if (shut && !ctrl_word[`DPM_CW_SWON]) st_d = P_RTSO;
      P_RTSO: if (!shut) st_d = P_SOD;
              else if (ctrl_word[`DPM_CW_SWON]) st_d = P_SWON;
      P_SWON: if (!shut) st_d = P_SOD;
              else if (ctrl_word[`DPM_CW_ENOP]) st_d = P_OPEN;
      P_OPEN: if (!shut) st_d = P_SOD;
              else if (!ctrl_word[`DPM_CW_ENOP]) st_d = P_SWON;
      P_FLT:  if (ctrl_word[`DPM_CW_FRST] && !flt) st_d = P_SOD;
      default: st_d = P_SOD;
    endcase
    if (flt && st_q != P_FLT)
      st_d = P_FLT;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= P_SOD;
      drv_cmd_q   <= `DPM_WORD_RST;
      stat_word_q <= `DPM_WORD_RST;
    end else begin
      // Held idle while bypassed so no stale run command survives a mode switch
      st_q <= enable ? st_d : P_SOD;
      drv_cmd_q <= `DPM_WORD_RST;
      drv_cmd_q[`DPM_DC_RUN]  <= enable && st_q == P_OPEN && !ctrl_word[`DPM_CW_HALT];
      drv_cmd_q[`DPM_DC_FRST] <= enable && st_q == P_FLT && ctrl_word[`DPM_CW_FRST];
      stat_word_q <= `DPM_WORD_RST;
      stat_word_q[`DPM_SW_RDY]  <= st_q == P_RTSO || st_q == P_SWON || st_q == P_OPEN;
      stat_word_q[`DPM_SW_SWON] <= st_q == P_SWON || st_q == P_OPEN;
      stat_word_q[`DPM_SW_OPEN] <= st_q == P_OPEN;
      stat_word_q[`DPM_SW_FLT]  <= st_q == P_FLT;
      stat_word_q[`DPM_SW_VEN]  <= drv_sts[`DPM_DS_RDY];
      stat_word_q[`DPM_SW_QS]   <= ctrl_word[`DPM_CW_QSTOP];
      stat_word_q[`DPM_SW_SOD]  <= st_q == P_SOD;
    end
  end

endmodule

// file: tb/dpm_core_assertions.sv
/*
  Checker for dpm_core: SDO answer handshake, mode display, mode choice,
  emergency and alarm relations, seen at the top module's ports only.
  Assumes it is bound onto dpm_core and one clock domain.
*/
`timescale 1ns/1ps
module dpm_core_assertions (
  // Clock and reset
  input wire        clock,
  input wire        rst_n,
  // SDO handshake
  input wire        sdo_req_valid,
  input wire        sdo_req_ready,
  input wire [2:0]  sdo_req_cmd,
  input wire [15:0] sdo_req_index,
  input wire [3:0]  sdo_req_size,
  input wire        sdo_rsp_valid,
  input wire        sdo_rsp_ready,
  input wire [31:0] sdo_rsp_data_q,
  input wire [3:0]  sdo_rsp_size_q,
  input wire        sdo_rsp_normal_q,
  input wire        sdo_rsp_abort_q,
  input wire [31:0] sdo_rsp_code_q,
  // State, mode and events
  input wire [3:0]  net_state_q,
  input wire        rxpdo_has_ctrl,
  input wire        drive_fault,
  input wire        emcy_valid_q,
  input wire [15:0] emcy_code_q,
  input wire        emcy_rx_valid,
  input wire        emcy_rx_refused_q,
  input wire        profile_active_q,
  input wire [7:0]  mode_display_q,
  input wire [7:0]  node_addr_q,
  input wire        node_address_alarm_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire take = sdo_req_valid && sdo_req_ready;
  wire run  = net_state_q[2] || net_state_q[3];
  wire ctrl = take && sdo_req_cmd == 3'h0 && sdo_req_index == 16'h6040 && sdo_req_size == 4'h2;

  AST_MODE_P: assert property (profile_active_q |-> mode_display_q == 8'h02)
    else $error("mode display not 02 in profile mode");
  AST_MODE_B: assert property (!profile_active_q |-> mode_display_q == 8'hFE)
    else $error("mode display not FE in bypass mode");
  AST_LOCK: assert property (ctrl && run && !profile_active_q |=> sdo_rsp_abort_q
    && sdo_rsp_code_q == 32'h08000022) else $error("control word not refused in bypass");
  AST_SEL_PDO: assert property (rxpdo_has_ctrl && run |-> ##[1:2] profile_active_q)
    else $error("mapped control word did not select profile");
  AST_SEL_SDO: assert property (ctrl && !run |-> ##[1:3] profile_active_q)
    else $error("control word write did not select profile");
  AST_ANS: assert property (take && sdo_req_cmd != 3'h5 |=> sdo_rsp_valid)
    else $error("request not answered next cycle");
  AST_HOLD: assert property (sdo_rsp_valid && !sdo_rsp_ready |=> sdo_rsp_valid
    && !sdo_req_ready && $stable(sdo_rsp_data_q) && $stable(sdo_rsp_code_q))
    else $error("answer dropped or changed before handshake");
  AST_EXP_LEN: assert property (take && sdo_req_cmd == 3'h0 && sdo_req_index == 16'h2001
    && sdo_req_size > 4'h4 |=> sdo_rsp_abort_q && sdo_rsp_code_q == 32'h06070010)
    else $error("oversized expedited write not aborted");
  AST_EXP_UL: assert property (sdo_rsp_valid && !sdo_rsp_abort_q && !sdo_rsp_normal_q
    |-> sdo_rsp_size_q <= 4'h4) else $error("expedited answer above four octets");
  AST_EMCY: assert property ($rose(drive_fault) |-> ##[1:3] (emcy_valid_q
    && emcy_code_q == 16'hFF00)) else $error("drive fault sent no emergency");
  AST_EMCY_RX: assert property (emcy_rx_valid |=> emcy_rx_refused_q)
    else $error("incoming emergency not refused");
  AST_ALARM: assert property (node_address_alarm_q |-> node_addr_q == 8'h00)
    else $error("alarm with nonzero node address");
  AST_RST: assert property ($rose(rst_n) |-> net_state_q == 4'h1)
    else $error("network state not INIT after reset");
endmodule

bind dpm_core dpm_core_assertions i_dpm_core_assertions (.*);

// file: tb/dpm_master.sv
/*
  Master-side model: one SDO request at a time with answer capture,
  network state requests and output process data.
  Assumes dpm_core handshakes; drives at falling clock edges.
*/
`timescale 1ns/1ps
module dpm_master (
  // Clock
  input  wire        clock,
  // SDO request
  output reg         sdo_req_valid,
  input  wire        sdo_req_ready,
  output reg  [2:0]  sdo_req_cmd,
  output reg  [15:0] sdo_req_index,
  output reg  [31:0] sdo_req_data,
  output reg  [3:0]  sdo_req_size,
  // SDO answer
  input  wire        sdo_rsp_valid,
  output reg         sdo_rsp_ready,
  input  wire [31:0] sdo_rsp_data_q,
  input  wire        sdo_rsp_last_q,
  input  wire        sdo_rsp_normal_q,
  input  wire        sdo_rsp_abort_q,
  input  wire [31:0] sdo_rsp_code_q,
  // Network state and process data
  input  wire [3:0]  net_state_q,
  output reg         al_req_valid,
  output reg  [3:0]  al_req_state,
  output reg         pdo_valid,
  output reg  [15:0] pdo_word
);
  reg [31:0] r_data;
  reg [31:0] r_code;
  reg        r_last;
  reg        r_normal;
  reg        r_abort;
  reg        to;
  integer    n;
  initial begin
    {sdo_req_valid, sdo_rsp_ready, al_req_valid, pdo_valid} = 4'h0;
    {sdo_req_cmd, sdo_req_index, sdo_req_data, sdo_req_size} = 55'h0;
    al_req_state = 4'h1;
    pdo_word = 16'h0000;
    to = 1'b0;
  end
  // Answer taken after w idle cycles to exercise a slow master
  task sdo(input [2:0] c, input [15:0] i, input [31:0] d, input [3:0] s, input integer w);
    begin
      @(negedge clock);
      sdo_req_cmd = c;
      sdo_req_index = i;
      sdo_req_data = d;
      sdo_req_size = s;
      sdo_req_valid = 1'b1;
      n = 0;
      while (sdo_req_ready !== 1'b1 && n < 40) begin
        @(negedge clock);
        n = n + 1;
      end
      @(negedge clock);
      sdo_req_valid = 1'b0;
      // Released data shows the inverse, never the last value
      sdo_req_data = ~d;
      to = (n == 40);
      n = 0;
      while (c != 3'h5 && sdo_rsp_valid !== 1'b1 && n < 40) begin
        @(negedge clock);
        n = n + 1;
      end
      if (c != 3'h5) begin
        to = to | (n == 40);
        repeat (w) @(negedge clock);
        r_data = sdo_rsp_data_q;
        r_code = sdo_rsp_code_q;
        r_last = sdo_rsp_last_q;
        r_normal = sdo_rsp_normal_q;
        r_abort = sdo_rsp_abort_q;
        sdo_rsp_ready = 1'b1;
        @(negedge clock);
        sdo_rsp_ready = 1'b0;
      end
    end
  endtask
  task al(input [3:0] st);
    begin
      @(negedge clock);
      al_req_state = st;
      al_req_valid = 1'b1;
      @(negedge clock);
      al_req_valid = 1'b0;
    end
  endtask
  task pdo(input [15:0] w);
    begin
      @(negedge clock);
      pdo_word = w;
      pdo_valid = (net_state_q == 4'h8);
      @(negedge clock);
      pdo_valid = 1'b0;
    end
  endtask
endmodule

// file: tb/test_dpm_core.sv
/*
  Testbench for dpm_core: mode choice, SDO service, emergencies, alarm.
  Assumes the master model dpm_master and the bound checker.
*/
`timescale 1ns/1ps
module test_dpm_core;
  reg         clock, rst_n, rxpdo_has_ctrl, drive_fault, adapter_fault, emcy_rx_valid;
  reg  [15:0] drv_sts;
  reg  [7:0]  node_addr_in;
  reg  [1:0]  comm_speed_in;
  wire        sdo_req_valid, sdo_req_ready, sdo_rsp_valid, sdo_rsp_ready, al_req_valid;
  wire        pdo_valid, sdo_rsp_last_q, sdo_rsp_normal_q, sdo_rsp_abort_q;
  wire        emcy_valid_q, emcy_rx_refused_q, profile_active_q, node_address_alarm_q;
  wire [2:0]  sdo_req_cmd, sdo_rsp_cmd_q;
  wire [3:0]  sdo_req_size, sdo_rsp_size_q, al_req_state, net_state_q;
  wire [15:0] sdo_req_index, pdo_word, drv_cmd_q, emcy_code_q;
  wire [31:0] sdo_req_data, sdo_rsp_data_q, sdo_rsp_code_q;
  wire [7:0]  mode_display_q, node_addr_q;
  reg  [7:0]  sdo_req_sub;
  wire [1:0]  comm_speed_q;
  wire [31:0] rd = i_dpm_master.r_data;
  wire [31:0] rc = i_dpm_master.r_code;
  wire        ra = i_dpm_master.r_abort;
  wire        rl = i_dpm_master.r_last;
  wire        rn = i_dpm_master.r_normal;
  integer     mismatches, comparisons, k;

  dpm_core   i_dpm_core (.*);
  dpm_master i_dpm_master (.*);

  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  task end_sim;
    begin
      $display("Counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task nw(input integer c);
    repeat (c) @(negedge clock);
  endtask
  // Wait budgets that run out end the run
  task q(input [2:0] c, input [15:0] i, input [31:0] d, input [3:0] s);
    begin
      i_dpm_master.sdo(c, i, d, s, k % 3);
      k = k + 1;
      if (i_dpm_master.to) begin
        mismatches = mismatches + 1;
        end_sim;
      end
    end
  endtask
  task t_reset(input [7:0] a);
    begin
      rst_n = 1'b0;
      nw(2);
      rst_n = 1'b1;
      nw(4);
      chk(net_state_q, 4'h1);
      chk(mode_display_q, 8'hFE);
      chk(node_address_alarm_q, a == 8'h00);
      node_addr_in = a + 8'h01;
      comm_speed_in = comm_speed_in ^ 2'h3;
      nw(3);
      chk(node_addr_q, a);
      chk(comm_speed_q, comm_speed_in ^ 2'h3);
      $display("reset test done");
    end
  endtask
  task t_modes;
    begin
      q(3'h3, 16'h6061, 32'h0, 4'h0);
      chk(rd, 32'hFE);
      chk({sdo_rsp_cmd_q, sdo_rsp_size_q}, 7'h31);
      q(3'h3, 16'h6041, 32'h0, 4'h0);
      nw(2);
      chk(profile_active_q, 1'b1);
      q(3'h3, 16'h6061, 32'h0, 4'h0);
      chk(rd, 32'h02);
      i_dpm_master.al(4'h2);
      i_dpm_master.al(4'h4);
      nw(2);
      chk(profile_active_q, 1'b0);
      q(3'h0, 16'h6040, 32'h6, 4'h2);
      chk(rc, 32'h08000022);
      rxpdo_has_ctrl = 1'b1;
      nw(2);
      chk(mode_display_q, 8'h02);
      rxpdo_has_ctrl = 1'b0;
      i_dpm_master.al(4'h2);
      q(3'h0, 16'h6040, 32'h6, 4'h2);
      nw(2);
      chk({ra, profile_active_q}, 2'h1);
      i_dpm_master.al(4'h4);
      i_dpm_master.al(4'h8);
      i_dpm_master.pdo(16'h1234);
      nw(2);
      chk(drv_cmd_q, 16'h1234);
      drv_sts = 16'h00A5;
      q(3'h3, 16'h2002, 32'h0, 4'h0);
      chk(rd, 32'h000000A5);
      $display("mode test done");
    end
  endtask
  task t_sdo;
    begin
      q(3'h0, 16'h2001, 32'h0, 4'h5);
      chk(rc, 32'h06070010);
      q(3'h3, 16'h1234, 32'h0, 4'h0);
      chk(rc, 32'h06020000);
      sdo_req_sub = 8'h01;
      q(3'h3, 16'h2001, 32'h0, 4'h0);
      chk(rc, 32'h06090011);
      sdo_req_sub = 8'h00;
      q(3'h0, 16'h2001, 32'hAB, 4'h2);
      q(3'h3, 16'h2001, 32'h0, 4'h0);
      chk(rd, 32'hAB);
      q(3'h1, 16'h2100, 32'h8, 4'h0);
      chk(ra, 1'b0);
      q(3'h2, 16'h2100, 32'h11223344, 4'h4);
      chk(rl, 1'b0);
      q(3'h2, 16'h2100, 32'h55667788, 4'h4);
      chk(rl, 1'b1);
      q(3'h2, 16'h2100, 32'h0, 4'h4);
      chk(rc, 32'h05040001);
      q(3'h3, 16'h2100, 32'h0, 4'h0);
      chk({rn, rd[30:0]}, 32'h80000008);
      q(3'h4, 16'h2100, 32'h0, 4'h0);
      chk(rd, 32'h11223344);
      q(3'h4, 16'h2100, 32'h0, 4'h0);
      chk({rl, rd[30:0]}, 32'hD5667788);
      q(3'h1, 16'h2100, 32'h8, 4'h0);
      q(3'h5, 16'h2100, 32'h0, 4'h0);
      q(3'h2, 16'h2100, 32'h0, 4'h4);
      chk(rc, 32'h05040001);
      $display("sdo test done");
    end
  endtask
  task emcy(input [15:0] code);
    integer n;
    begin
      n = 0;
      while (emcy_valid_q !== 1'b1 && n < 8) begin
        nw(1);
        n = n + 1;
      end
      if (n == 8) begin
        mismatches = mismatches + 1;
        end_sim;
      end
      chk(emcy_code_q, code);
      nw(1);
      chk(emcy_valid_q, 1'b0);
    end
  endtask
  task t_emcy;
    begin
      drive_fault = 1'b1;
      emcy(16'hFF00);
      adapter_fault = 1'b1;
      emcy(16'h5000);
      emcy_rx_valid = 1'b1;
      nw(1);
      emcy_rx_valid = 1'b0;
      chk(emcy_rx_refused_q, 1'b1);
      drive_fault = 1'b0;
      adapter_fault = 1'b0;
      $display("emergency test done");
    end
  endtask
  initial begin
    {sdo_req_sub, rst_n, rxpdo_has_ctrl, drive_fault, adapter_fault, emcy_rx_valid} = 13'h0000;
    drv_sts = 16'h0006;
    node_addr_in = 8'h00;
    comm_speed_in = 2'h1;
    mismatches = 0;
    comparisons = 0;
    k = 0;
    t_reset(8'h00);
    t_modes;
    t_sdo;
    t_emcy;
    t_reset(8'h01);
    end_sim;
  end
endmodule
